// [logic/adcfmt_pkg.sv]
// Purpose: shared constants of the output data format stage
// Assumes: 14-bit samples in offset binary from the converter core
// Notes: serial frame is one r/w bit, seven address bits and eight data bits
package adcfmt_pkg;

  // serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam int ADDR_W = 7;
  localparam int REG_W = 8;
  localparam logic [4:0] CNT_FRAME = 5'h10;
  localparam logic [4:0] CNT_HDR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;

  // register map
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_FORMAT = 7'h04;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam int SOFT_RESET_BIT = 7;

  // format register fields
  localparam int FMT_TEST_HI = 5;
  localparam int FMT_TEST_LO = 3;
  localparam int FMT_POLARITY_BIT = 2;
  localparam int FMT_SCRAMBLE_BIT = 1;
  localparam int FMT_SIGNED_BIT = 0;

  // test pattern codes
  localparam logic [2:0] TEST_OFF = 3'h0;
  localparam logic [2:0] TEST_ZEROS = 3'h1;
  localparam logic [2:0] TEST_ONES = 3'h3;
  localparam logic [2:0] TEST_CHECKER = 3'h5;
  localparam logic [2:0] TEST_TOGGLE = 3'h7;

  // output word
  localparam int DATA_W = 14;
  localparam logic [13:0] CHECKER_A = 14'h1555;
  localparam logic [13:0] CHECKER_B = 14'h2aaa;
  localparam logic [13:0] POLARITY_MASK = 14'h2aaa;
  localparam logic [13:0] ALL_ZERO = 14'h0000;
  localparam logic [13:0] ALL_ONE = 14'h3fff;

endpackage

// [logic/adcfmt_serial_port.sv]
// Purpose: serial configuration port slave, pins sampled on clk
// Assumes: sck is much slower than clk, at most clk/8
// Notes: sdo is open drain, only ever pulled low
`timescale 1ns/1ps
`default_nettype none
module adcfmt_serial_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial pins
  input wire logic cs_b_pin,
  input wire logic sck_pin,
  input wire logic sdi_pin,
  output logic sdo_out,
  output logic sdo_oe_b,
  // register side
  input wire logic [7:0] rd_data,
  output logic [6:0] hdr_addr,
  output logic wr_pulse,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data
);

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic sck_prev_r;
  logic cs_prev_r;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [15:0] shift_r;
  logic [7:0] hdr_r;
  logic [7:0] rd_shift_r;
  logic sdo_oe_b_r;
  logic sdo_oe_b_nxt;
  logic [7:0] rd_shift_nxt;

  wire cs_b_s = sync2_r[2];
  wire sck_s = sync2_r[1];
  wire sdi_s = sync2_r[0];
  wire sck_rise = ~cs_b_s & sck_s & ~sck_prev_r;
  wire sck_fall = ~cs_b_s & ~sck_s & sck_prev_r;
  wire frame_end = cs_b_s & ~cs_prev_r;
  wire take_bit = sck_rise & (cnt_r < adcfmt_pkg::CNT_FRAME);
  wire hdr_done = take_bit & (cnt_r == adcfmt_pkg::CNT_HDR_LAST);
  wire is_read = hdr_r[adcfmt_pkg::HDR_BITS-1];
  wire rd_first = sck_fall & is_read & (cnt_r == adcfmt_pkg::CNT_DATA_FIRST);
  wire rd_next = sck_fall & is_read & (cnt_r > adcfmt_pkg::CNT_DATA_FIRST) & (cnt_r < adcfmt_pkg::CNT_FRAME);

  assign cnt_nxt = cs_b_s ? 5'h00 : (take_bit ? 5'(cnt_r + 5'h01) : cnt_r);

  // data bit leaves msb first, pin pulled low for a zero
  always_comb begin
    sdo_oe_b_nxt = sdo_oe_b_r;
    rd_shift_nxt = rd_shift_r;
    if (cs_b_s || (sck_fall && cnt_r == adcfmt_pkg::CNT_FRAME)) begin
      sdo_oe_b_nxt = 1'b1;
    end else if (rd_first) begin
      sdo_oe_b_nxt = rd_data[adcfmt_pkg::REG_W-1];
      rd_shift_nxt = {rd_data[adcfmt_pkg::REG_W-2:0], 1'b0};
    end else if (rd_next) begin
      sdo_oe_b_nxt = rd_shift_r[adcfmt_pkg::REG_W-1];
      rd_shift_nxt = {rd_shift_r[adcfmt_pkg::REG_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      sck_prev_r <= 1'b1;
      cs_prev_r <= 1'b1;
    end else begin
      sync1_r <= {cs_b_pin, sck_pin, sdi_pin};
      sync2_r <= sync1_r;
      sck_prev_r <= sck_s;
      cs_prev_r <= cs_b_s;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      hdr_r <= 8'h00;
      rd_shift_r <= 8'h00;
      sdo_oe_b_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      rd_shift_r <= rd_shift_nxt;
      sdo_oe_b_r <= sdo_oe_b_nxt;
      if (take_bit) begin
        shift_r <= {shift_r[14:0], sdi_s};
      end
      if (hdr_done) begin
        hdr_r <= {shift_r[6:0], sdi_s};
      end
    end
  end

  // write only for a full frame with r/w low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pulse <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end else begin
      wr_pulse <= frame_end & (cnt_r == adcfmt_pkg::CNT_FRAME) & ~is_read;
      if (frame_end) begin
        wr_addr <= hdr_r[adcfmt_pkg::ADDR_W-1:0];
        wr_data <= shift_r[adcfmt_pkg::REG_W-1:0];
      end
    end
  end

  // sdo level is always low; the enable alone shapes the wire
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdo_out <= 1'b0;
    end else begin
      sdo_out <= 1'b0;
    end
  end

  assign sdo_oe_b = sdo_oe_b_r;
  assign hdr_addr = hdr_r[adcfmt_pkg::ADDR_W-1:0];

endmodule
`default_nettype wire

// [logic/adcfmt_format.sv]
// Purpose: output data format stage, configured through the serial port
// Assumes: clk is the sample clock, one new sample word per clk edge
// Notes: output word registered once; pipeline latency one clk
//   order of the data path: coding, scrambler, alternate polarity
//   reserved pattern codes pass normal data rather than a pattern
`timescale 1ns/1ps
`default_nettype none
module adcfmt_format (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial configuration pins
  input wire logic cs_b_pin,
  input wire logic sck_pin,
  input wire logic sdi_pin,
  output logic sdo_out,
  output logic sdo_oe_b,
  // converter core samples, offset binary
  input wire logic [13:0] core_sample_bits,
  input wire logic core_overrange_flag,
  // formatted output word
  output logic [13:0] sample_bits,
  output logic overrange_flag
);

  // format register
  logic [7:0] format_r;
  logic [7:0] format_nxt;
  logic format_load;

  // alternating pattern phase
  logic phase_r;
  logic phase_nxt;

  // output word
  logic [13:0] sample_bits_r;
  logic [13:0] sample_bits_nxt;
  logic overrange_flag_r;
  logic overrange_flag_nxt;

  // data path stages
  logic [13:0] coded_bits;
  logic [13:0] scramble_mask;
  logic [13:0] scrambled_bits;
  logic [13:0] polar_bits;

  // serial port side
  logic [7:0] rd_data;
  logic [6:0] hdr_addr;
  logic wr_pulse;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  adcfmt_serial_port u_port (
    .clk(clk),
    .rst_b(rst_b),
    .cs_b_pin(cs_b_pin),
    .sck_pin(sck_pin),
    .sdi_pin(sdi_pin),
    .sdo_out(sdo_out),
    .sdo_oe_b(sdo_oe_b),
    .rd_data(rd_data),
    .hdr_addr(hdr_addr),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // register decode
  wire addr_is_format = (wr_addr == adcfmt_pkg::ADDR_FORMAT);
  wire addr_is_reset = (wr_addr == adcfmt_pkg::ADDR_RESET);
  wire wr_format = wr_pulse & addr_is_format;
  wire soft_reset = wr_pulse & addr_is_reset & wr_data[adcfmt_pkg::SOFT_RESET_BIT];
  // any format write restarts the pattern phase
  assign format_load = wr_format | soft_reset;

  // reset register reads back zero; unmapped addresses also zero
  wire rd_format = (hdr_addr == adcfmt_pkg::ADDR_FORMAT);
  assign rd_data = rd_format ? format_r : 8'h00;

  // clear wins, reset bit itself is never stored
  assign format_nxt = soft_reset ? adcfmt_pkg::FORMAT_RESET : (wr_format ? wr_data : format_r);

  // field decode; bits 7..6 have no reader here
  wire [2:0] test_pattern_select = format_r[adcfmt_pkg::FMT_TEST_HI:adcfmt_pkg::FMT_TEST_LO];
  wire alternate_polarity_enable = format_r[adcfmt_pkg::FMT_POLARITY_BIT];
  wire output_scrambler_enable = format_r[adcfmt_pkg::FMT_SCRAMBLE_BIT];
  wire signed_coding_select = format_r[adcfmt_pkg::FMT_SIGNED_BIT];
  wire use_signed = signed_coding_select & ~alternate_polarity_enable;

  // two's complement is offset binary with msb flipped
  assign coded_bits = use_signed ?
    {~core_sample_bits[adcfmt_pkg::DATA_W-1], core_sample_bits[adcfmt_pkg::DATA_W-2:0]} : core_sample_bits;

  // bit 0 spread over every higher bit position
  assign scramble_mask = {{(adcfmt_pkg::DATA_W-1){coded_bits[0]}}, 1'b0};
  // bit 0 kept clear so receiver can undo
  assign scrambled_bits = output_scrambler_enable ? (coded_bits ^ scramble_mask) : coded_bits;

  // odd bits inverted after scrambling, undone first by receiver
  assign polar_bits = alternate_polarity_enable ? (scrambled_bits ^ adcfmt_pkg::POLARITY_MASK) : scrambled_bits;

  // alternating patterns restart on the first word after a format write
  wire pattern_checker = (test_pattern_select == adcfmt_pkg::TEST_CHECKER);
  wire pattern_toggle = (test_pattern_select == adcfmt_pkg::TEST_TOGGLE);
  wire pattern_alternates = pattern_checker | pattern_toggle;
  assign phase_nxt = (pattern_alternates & ~format_load) ? ~phase_r : 1'b0;

  // checkerboard pair, flag high on the first word
  wire [13:0] checker_bits = phase_r ? adcfmt_pkg::CHECKER_B : adcfmt_pkg::CHECKER_A;
  wire checker_flag = ~phase_r;
  // all clear first, then all set
  wire [13:0] toggle_bits = phase_r ? adcfmt_pkg::ALL_ONE : adcfmt_pkg::ALL_ZERO;
  wire toggle_flag = phase_r;

  always_comb begin
    sample_bits_nxt = polar_bits;
    case (test_pattern_select)
      adcfmt_pkg::TEST_OFF: begin
        sample_bits_nxt = polar_bits;
      end
      adcfmt_pkg::TEST_ZEROS: begin
        sample_bits_nxt = adcfmt_pkg::ALL_ZERO;
      end
      adcfmt_pkg::TEST_ONES: begin
        sample_bits_nxt = adcfmt_pkg::ALL_ONE;
      end
      adcfmt_pkg::TEST_CHECKER: begin
        sample_bits_nxt = checker_bits;
      end
      adcfmt_pkg::TEST_TOGGLE: begin
        sample_bits_nxt = toggle_bits;
      end
      // unused codes fall back to normal data
      default: begin
        sample_bits_nxt = polar_bits;
      end
    endcase
  end

  // flag follows the same selection as the word
  always_comb begin
    overrange_flag_nxt = core_overrange_flag;
    case (test_pattern_select)
      adcfmt_pkg::TEST_OFF: begin
        overrange_flag_nxt = core_overrange_flag;
      end
      adcfmt_pkg::TEST_ZEROS: begin
        overrange_flag_nxt = 1'b0;
      end
      adcfmt_pkg::TEST_ONES: begin
        overrange_flag_nxt = 1'b1;
      end
      adcfmt_pkg::TEST_CHECKER: begin
        overrange_flag_nxt = checker_flag;
      end
      adcfmt_pkg::TEST_TOGGLE: begin
        overrange_flag_nxt = toggle_flag;
      end
      default: begin
        overrange_flag_nxt = core_overrange_flag;
      end
    endcase
  end

  // all eight bits kept so the host reads back what it wrote
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      format_r <= adcfmt_pkg::FORMAT_RESET;
    end else begin
      format_r <= format_nxt;
    end
  end

  // pattern phase advances once per word in checker and toggle modes, else held at zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // whole word registered at once, never a mix of settings
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_bits_r <= adcfmt_pkg::ALL_ZERO;
    end else begin
      sample_bits_r <= sample_bits_nxt;
    end
  end

  // flag shares the word's edge so the pair never splits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overrange_flag_r <= 1'b0;
    end else begin
      overrange_flag_r <= overrange_flag_nxt;
    end
  end

  // outputs straight from the word registers
  assign sample_bits = sample_bits_r;
  assign overrange_flag = overrange_flag_r;

endmodule
`default_nettype wire

// [test/adcfmt_format_assertions.sv]
// Purpose: output word checker, shadows format reg from pins
// Assumes: sck slow against clk
// Notes: data checks wait until cs_b has rested high
`timescale 1ns/1ps
`default_nettype none
module adcfmt_format_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial pins
  input wire logic cs_b_pin,
  input wire logic sck_pin,
  input wire logic sdi_pin,
  input wire logic sdo_out,
  input wire logic sdo_oe_b,
  // words
  input wire logic [13:0] core_sample_bits,
  input wire logic core_overrange_flag,
  input wire logic [13:0] sample_bits,
  input wire logic overrange_flag
);
  logic sck_d_r, cs_d_r;
  logic [4:0] cnt_r;
  logic [15:0] sh_r;
  logic [7:0] fmt_r;
  logic [2:0] q_r;
  wire quiet = q_r == 3'h7;
  wire [5:0] m = fmt_r[5:0];
  wire [13:0] c = core_sample_bits;
  wire fin = cs_b_pin && !cs_d_r && cnt_r == 5'h10 && !sh_r[15];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {sck_d_r, cs_d_r, cnt_r, sh_r, fmt_r, q_r} <= '0;
    end else begin
      sck_d_r <= sck_pin;
      cs_d_r <= cs_b_pin;
      q_r <= !cs_b_pin ? 3'h0 : (quiet ? q_r : q_r + 3'h1);
      cnt_r <= cs_b_pin ? 5'h00 : cnt_r + 5'(sck_pin && !sck_d_r && cnt_r < 5'h10);
      if (sck_pin && !sck_d_r && cnt_r < 5'h10) sh_r <= {sh_r[14:0], sdi_pin};
      // soft reset wins, bits 6..0 of it ignored
      if (fin && sh_r[14:8] == 7'h04) fmt_r <= sh_r[7:0];
      if (fin && sh_r[14:8] == 7'h00 && sh_r[7]) fmt_r <= 8'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_plain_pass: assert property (quiet && m == 6'h00 |=>
    sample_bits == $past(c) && overrange_flag == $past(core_overrange_flag)) else $error("plain word wrong");
  a_zero_fill: assert property (quiet && m[5:3] == 3'h1 |=>
    sample_bits == 14'h0000 && !overrange_flag) else $error("zero pattern wrong");
  a_one_fill: assert property (quiet && m[5:3] == 3'h3 |=>
    sample_bits == 14'h3fff && overrange_flag) else $error("ones pattern wrong");
  a_checker_alt: assert property (quiet && m[5:3] == 3'h5 && overrange_flag |->
    sample_bits == 14'h1555 ##1 !overrange_flag && sample_bits == 14'h2aaa) else $error("checker wrong");
  a_toggle_alt: assert property (quiet && m[5:3] == 3'h7 |=>
    overrange_flag != $past(overrange_flag) && sample_bits == {14{overrange_flag}}) else $error("toggle wrong");
  a_signed_flip: assert property (quiet && m == 6'h01 |=>
    sample_bits == ($past(c) ^ 14'h2000)) else $error("signed coding wrong");
  a_polar_offset: assert property (quiet && m == 6'h05 |=>
    sample_bits == ($past(c) ^ 14'h2aaa)) else $error("polarity word wrong");
  a_scramble_xor: assert property (quiet && m == 6'h02 |=>
    sample_bits == ($past(c) ^ {{13{$past(c[0])}}, 1'b0})) else $error("scrambled word wrong");
  a_sdo_idle: assert property (cs_b_pin [*4] |-> sdo_oe_b && !sdo_out)
    else $error("sdo driven while idle");
  c_checker: cover property (quiet && m[5:3] == 3'h5);
  c_scramble: cover property (quiet && m == 6'h02);
  c_read: cover property (!sdo_oe_b);
endmodule
bind adcfmt_format adcfmt_format_assertions i_chk (.clk(clk), .rst_b(rst_b), .cs_b_pin(cs_b_pin),
  .sck_pin(sck_pin), .sdi_pin(sdi_pin), .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b),
  .core_sample_bits(core_sample_bits), .core_overrange_flag(core_overrange_flag),
  .sample_bits(sample_bits), .overrange_flag(overrange_flag));
`default_nettype wire

// [test/adcfmt_spi_host.sv]
// Purpose: configuration host model on the serial pins
// Assumes: pins launched on falling clk, h clk per sck level
// Notes: sdi inverted after a frame so stale data never passes
`timescale 1ns/1ps
`default_nettype none
module adcfmt_spi_host (
  // clock
  input wire logic clk,
  // serial pins
  output logic cs_b,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic frame(input logic [15:0] w, input int h, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk) cs_b = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      repeat (h) @(negedge clk);
      sck = 1'b1;
      if (i < 8) rd = {rd[6:0], sdo};
      repeat (h) @(negedge clk);
      sck = 1'b0;
    end
    repeat (h) @(negedge clk);
    cs_b = 1'b1;
    sdi = ~sdi;
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// [test/adcfmt_format_tb.sv]
// Purpose: self-checking bench of the output format stage
// Assumes: host model drives all frames
// Notes: pattern phase counted from the end of each format or reset write frame
`timescale 1ns/1ps
`default_nettype none
module adcfmt_format_tb;
  logic clk, rst_b, cs_b, sck, sdi, sdo_out, sdo_oe_b, of_in, of_o, on;
  logic [13:0] d_in, d_o;
  logic [7:0] f, rd;
  logic [14:0] q[$];
  int num_errors, total_checks, seed, ph, i;
  // host sends only the legal pattern codes
  logic [7:0] modes [10] = '{8'h00, 8'h43, 8'h01, 8'hc2, 8'h05, 8'h07, 8'h08, 8'h18, 8'h28, 8'h38};
  wire sdo = sdo_oe_b ? 1'b1 : sdo_out;
  adcfmt_format i_adcfmt_format (.clk(clk), .rst_b(rst_b), .cs_b_pin(cs_b), .sck_pin(sck), .sdi_pin(sdi),
    .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b), .core_sample_bits(d_in), .core_overrange_flag(of_in),
    .sample_bits(d_o), .overrange_flag(of_o));
  adcfmt_spi_host i_adcfmt_spi_host (.clk(clk), .cs_b(cs_b), .sck(sck), .sdi(sdi), .sdo(sdo));
  function automatic logic [14:0] expw(logic [7:0] m, logic [14:0] w, int p);
    logic [13:0] d;
    d = w[13:0];
    case (m[5:3])
      3'h1: return 15'h0000;
      3'h3: return 15'h7fff;
      3'h5: return p[0] ? 15'h2aaa : 15'h5555;
      3'h7: return p[0] ? 15'h7fff : 15'h0000;
      default: ;
    endcase
    // polarity forces offset binary
    if (m[0] && !m[2]) d[13] = ~d[13];
    if (m[1]) d[13:1] = d[13:1] ^ {13{d[0]}};
    if (m[2]) d = d ^ 14'h2aaa;
    return {w[14], d};
  endfunction
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cfg(input logic [6:0] a, input logic [7:0] v, input logic [7:0] nf);
    on = 1'b0;
    i_adcfmt_spi_host.frame({1'b0, a, v}, 4, rd);
    #1;
    f = nf;
    // next noted word is the fourth since the format write landed
    if (a == 7'h04 || a == 7'h00) ph = 3;
    on = 1'b1;
  endtask
  task automatic rdb(input logic [6:0] a, input logic [7:0] e, input int h);
    i_adcfmt_spi_host.frame({1'b1, a, 8'h00}, h, rd);
    check({7'h00, rd}, {7'h00, e}); // read back
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    {of_in, d_in} = 15'($random(seed));
    if (on) q.push_back(expw(f, {of_in, d_in}, ph));
    ph++;
  end
  always @(posedge clk) begin
    #2;
    if (q.size() > 0) check({of_o, d_o}, q.pop_front()); // word stream
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    {of_in, d_in} = 15'h0000;
    rst_b = 1'b0;
    on = 1'b0;
    f = 8'h00;
    seed = 48;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    // bits 7..6 in 8'hc2 must steer nothing
    for (i = 0; i < 10; i++) begin
      cfg(7'h04, modes[i], modes[i]);
      rdb(7'h04, modes[i], 4 + 5 * (i % 2));
      repeat (16) @(negedge clk);
    end
    cfg(7'h11, 8'hff, f);
    rdb(7'h11, 8'h00, 4);
    cfg(7'h00, 8'h80, 8'h00);
    rdb(7'h04, 8'h00, 9);
    repeat (16) @(negedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
